/* fail_safe_map.svh */
`ifndef FAIL_SAFE_MAP_SVH
`define FAIL_SAFE_MAP_SVH

// Clock period in ns
`define FS_CLK_NS        50
// Times in us
`define FS_WD_PERIOD_US  256000
`define FS_RST_PULSE_US  1000
`define FS_CLAMP_US      100000
`define FS_BUS_IDLE_US   8000000

// Watchdog failures that force the safe state
`define FS_WD_FAIL_MAX   4'h8

// Release commands
`define FS_RELEASE_WORD0 16'hdd00
`define FS_RELEASE_WORD1 16'hdd80

// Configuration code: bit 2 marks a valid selection
`define FS_CFG_VALID_BIT 2

// Cause flag positions
`define FS_CAUSE_WD      0
`define FS_CAUSE_SUPPLY  1
`define FS_CAUSE_CLAMP   2
`define FS_CAUSE_CUT     3
`define FS_CAUSE_W       4

// Reset values
`define FS_RST_CAUSE     4'h0
`define FS_RST_VARIANT   2'h0

`endif

/* fail_safe_pkg.sv */
package fail_safe_pkg;

  // Variant order equals the inverted low two bits of the configuration code
  typedef enum logic [1:0] {
    VAR_A  = 2'h0,
    VAR_B1 = 2'h1,
    VAR_B2 = 2'h2,
    VAR_B3 = 2'h3
  } variant_t;

  typedef enum logic [1:0] {
    FS_NORMAL  = 2'h0,
    FS_MONITOR = 2'h1,
    FS_OFF     = 2'h3
  } fs_state_t;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // A change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VAL[WIDTH-1:0];
      stage2 <= RESET_VAL[WIDTH-1:0];
      stage3 <= RESET_VAL[WIDTH-1:0];
      dout   <= RESET_VAL[WIDTH-1:0];
    end else if (clkEn) begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout   <= next_dout;
    end
  end
endmodule // pin_sync

/* fail_safe_supply_controller.sv */
`timescale 1ns/1ps
`include "fail_safe_map.svh"
module fail_safe_supply_controller #(
  parameter int unsigned WD_PERIOD_CYC = (`FS_WD_PERIOD_US * 1000) / `FS_CLK_NS,
  parameter int unsigned RST_PULSE_CYC = (`FS_RST_PULSE_US * 1000 + `FS_CLK_NS - 1) / `FS_CLK_NS,
  parameter int unsigned CLAMP_CYC = (`FS_CLAMP_US * 1000 + `FS_CLK_NS - 1) / `FS_CLK_NS,
  parameter int unsigned BUS_IDLE_CYC =
    32'((64'(`FS_BUS_IDLE_US) * 64'd1000 + 64'(`FS_CLK_NS) - 64'd1) / 64'(`FS_CLK_NS))
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      clkEn,
  input  wire logic [1:0]                strapClass,
  input  wire logic                      initDone,
  input  wire logic                      cfgWrite,
  input  wire logic [2:0]                cfgCode,
  input  wire logic                      wdRefreshOk,
  input  wire logic                      wdSecondSel,
  input  wire logic                      supplyLowPin,
  input  wire logic                      resetSenseLowPin,
  input  wire logic                      canActivityPin,
  input  wire logic                      linActivityPin,
  input  wire logic                      wake1Pin,
  input  wire logic                      wake1WakeEn,
  input  wire logic                      spiWordValid,
  input  wire logic [15:0]               spiWord,
  input  wire logic                      flagsClear,
  input  wire logic [`FS_CAUSE_W-1:0]    flagsClearMask,
  output logic                           safe_n,
  output logic                           supplyEnable,
  output logic                           resetOut_n,
  output fail_safe_pkg::variant_t        variantSel,
  output logic [`FS_CAUSE_W-1:0]         causeFlags,
  output logic                           inSafeState,
  output logic                           busIdleExpired
);
  import fail_safe_pkg::*;
  logic [6:0]       syncOut;
  logic             supplyLow;
  logic             resetSenseLow;
  logic             canAct;
  logic             linAct;
  logic             wake1;
  logic [1:0]       strapSync;
  pin_sync #(
    .WIDTH     (7),
    .RESET_VAL (32'h0000_0010)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .din     ({strapClass, wake1Pin, linActivityPin, canActivityPin,
                resetSenseLowPin, supplyLowPin}),
    .dout    (syncOut)
  );
  assign supplyLow     = syncOut[0];
  assign resetSenseLow = syncOut[1];
  assign canAct        = syncOut[2];
  assign linAct        = syncOut[3];
  assign wake1         = syncOut[4];
  assign strapSync     = syncOut[6:5];
  variant_t variant;
  variant_t next_variant;
  logic     overridden;
  logic     next_overridden;
  always_comb begin
    next_variant    = variant;
    next_overridden = overridden;
    if (cfgWrite && cfgCode[`FS_CFG_VALID_BIT]) begin
      next_variant    = variant_t'(~cfgCode[1:0]);
      next_overridden = 1'b1;
    end else if (initDone && !overridden) begin
      next_variant = variant_t'(strapSync);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      variant    <= variant_t'(`FS_RST_VARIANT);
      overridden <= 1'b0;
    end else if (clkEn) begin
      variant    <= next_variant;
      overridden <= next_overridden;
    end
  end
  fs_state_t   state;
  logic [31:0] wdTimer;
  logic [31:0] next_wdTimer;
  logic [31:0] pulseTimer;
  logic [31:0] next_pulseTimer;
  logic [3:0]  wdFails;
  logic [3:0]  next_wdFails;
  logic [31:0] clampTimer;
  logic [31:0] next_clampTimer;
  logic        clampFault;
  logic        next_clampFault;
  logic [31:0] idleTimer;
  logic [31:0] next_idleTimer;
  logic        next_busIdleExpired;
  logic        next_resetOut_n;
  logic        wdPulseEvt;
  logic        wdSafeTrig;
  logic        wakeEvt;
  assign wakeEvt = (state == FS_OFF) && (canAct || linAct || (wake1 && wake1WakeEn));
  assign wdPulseEvt = (state != FS_OFF) && !wdRefreshOk && (wdTimer == WD_PERIOD_CYC - 1);
  assign wdSafeTrig = wdPulseEvt && (!wdSecondSel || wdFails != 4'h0);
  always_comb begin
    next_wdTimer        = wdTimer;
    next_wdFails        = wdFails;
    next_pulseTimer     = (pulseTimer != 32'h0000_0000) ? pulseTimer - 32'h0000_0001 : pulseTimer;
    next_clampTimer     = clampTimer;
    next_clampFault     = clampFault;
    next_idleTimer      = idleTimer;
    next_busIdleExpired = busIdleExpired;
    if (wakeEvt) begin
      next_wdTimer    = 32'h0000_0000;
      next_wdFails    = 4'h0;
      next_pulseTimer = RST_PULSE_CYC;
    end else if (wdRefreshOk) begin
      next_wdTimer = 32'h0000_0000;
      next_wdFails = 4'h0;
    end else if (wdPulseEvt) begin
      next_wdTimer    = 32'h0000_0000;
      next_pulseTimer = RST_PULSE_CYC;
      if (wdFails != `FS_WD_FAIL_MAX) begin
        next_wdFails = wdFails + 4'h1;
      end
    end else if (state != FS_OFF) begin
      next_wdTimer = wdTimer + 32'h0000_0001;
    end
    if (resetSenseLow) begin
      if (clampTimer != CLAMP_CYC) begin
        next_clampTimer = clampTimer + 32'h0000_0001;
      end else begin
        next_clampFault = 1'b1;
      end
    end else begin
      next_clampTimer = 32'h0000_0000;
      next_clampFault = 1'b0;
    end
    if (canAct) begin
      next_idleTimer      = 32'h0000_0000;
      next_busIdleExpired = 1'b0;
    end else if (idleTimer != BUS_IDLE_CYC - 1) begin
      next_idleTimer = idleTimer + 32'h0000_0001;
    end else begin
      next_busIdleExpired = 1'b1;
    end
    next_resetOut_n = !(supplyLow || (next_pulseTimer != 32'h0000_0000));
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdTimer        <= 32'h0000_0000;
      wdFails        <= 4'h0;
      pulseTimer     <= 32'h0000_0000;
      clampTimer     <= 32'h0000_0000;
      clampFault     <= 1'b0;
      idleTimer      <= 32'h0000_0000;
      busIdleExpired <= 1'b0;
      resetOut_n     <= 1'b0;
    end else if (clkEn) begin
      wdTimer        <= next_wdTimer;
      wdFails        <= next_wdFails;
      pulseTimer     <= next_pulseTimer;
      clampTimer     <= next_clampTimer;
      clampFault     <= next_clampFault;
      idleTimer      <= next_idleTimer;
      busIdleExpired <= next_busIdleExpired;
      resetOut_n     <= next_resetOut_n;
    end
  end
  fs_state_t               next_state;
  logic                    safeActive;
  logic                    next_safeActive;
  logic                    next_supplyEnable;
  logic [`FS_CAUSE_W-1:0]  next_causeFlags;
  logic [`FS_CAUSE_W-1:0]  causeSet;
  logic                    refreshSeen;
  logic                    next_refreshSeen;
  logic                    wake1Prev;
  logic                    wake1Fell;
  logic                    next_wake1Fell;
  logic                    failActive;
  logic                    recovered;
  logic                    cutCond;
  logic                    releaseCmd;
  assign failActive = (wdFails == `FS_WD_FAIL_MAX) || supplyLow || clampFault;
  assign recovered  = !supplyLow && !resetSenseLow && refreshSeen;
  assign releaseCmd = spiWordValid
                      && (spiWord == `FS_RELEASE_WORD0 || spiWord == `FS_RELEASE_WORD1);
  always_comb begin
    case (variant)
      VAR_A:   cutCond = 1'b0;
      VAR_B1:  cutCond = busIdleExpired;
      VAR_B2:  cutCond = wake1Fell;
      VAR_B3:  cutCond = busIdleExpired && wake1Fell;
      default: cutCond = 1'b0;
    endcase
  end
  always_comb begin
    next_state       = state;
    next_supplyEnable = supplyEnable;
    next_refreshSeen = refreshSeen || wdRefreshOk;
    next_wake1Fell   = wake1Fell;
    causeSet         = '0;
    causeSet[`FS_CAUSE_WD]     = wdSafeTrig;
    causeSet[`FS_CAUSE_SUPPLY] = supplyLow && state != FS_OFF;
    causeSet[`FS_CAUSE_CLAMP]  = clampFault;
    case (state)
      FS_NORMAL: begin
        next_wake1Fell = 1'b0;
        if (failActive) begin
          next_state       = FS_MONITOR;
          next_refreshSeen = wdRefreshOk;
        end
      end
      FS_MONITOR: begin
        if (wake1Prev && !wake1) begin
          next_wake1Fell = 1'b1;
        end
        if (recovered) begin
          next_state = FS_NORMAL;
        end else if (cutCond) begin
          next_state        = FS_OFF;
          next_supplyEnable = 1'b0;
          causeSet[`FS_CAUSE_CUT] = 1'b1;
        end
      end
      FS_OFF: begin
        if (wakeEvt) begin
          next_state        = FS_NORMAL;
          next_supplyEnable = 1'b1;
        end
      end
      default: begin
        next_state        = FS_NORMAL;
        next_supplyEnable = 1'b1;
      end
    endcase
    // Set wins over clear and over release
    next_causeFlags = (causeFlags & ~(flagsClear ? flagsClearMask : '0)) | causeSet;
    if (causeSet != '0) begin
      next_safeActive = 1'b1;
    end else if (releaseCmd && causeFlags == '0) begin
      next_safeActive = 1'b0;
    end else begin
      next_safeActive = safeActive;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= FS_NORMAL;
      supplyEnable <= 1'b1;
      safeActive   <= 1'b0;
      causeFlags   <= `FS_RST_CAUSE;
      refreshSeen  <= 1'b0;
      wake1Prev    <= 1'b1;
      wake1Fell    <= 1'b0;
    end else if (clkEn) begin
      state        <= next_state;
      supplyEnable <= next_supplyEnable;
      safeActive   <= next_safeActive;
      causeFlags   <= next_causeFlags;
      refreshSeen  <= next_refreshSeen;
      wake1Prev    <= wake1;
      wake1Fell    <= next_wake1Fell;
    end
  end
  assign safe_n      = !safeActive;
  assign variantSel  = variant;
  assign inSafeState = (state != FS_NORMAL);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !clkEn);
  a_off_cuts_supply: assert property (
    state == FS_OFF |-> !supplyEnable)
    else $error("Supply on while in the off state");
  a_cfg_overrides: assert property (
    cfgWrite && cfgCode[2] |=> variant == variant_t'(~$past(cfgCode[1:0])))
    else $error("Valid configuration write did not set the variant");
  a_strap_sampled: assert property (
    initDone && !overridden && !(cfgWrite && cfgCode[2]) |=> variant == $past(strapSync))
    else $error("Strap not sampled at end of initialisation");
  a_variant_a_on: assert property (
    state == FS_MONITOR && variant == VAR_A |=> state != FS_OFF)
    else $error("Variant A cut the supply");
  a_b1_idle_cut: assert property (
    state == FS_MONITOR && variant == VAR_B1 && busIdleExpired && !recovered
    |=> state == FS_OFF ##0 !supplyEnable)
    else $error("Variant B1 did not cut after idle timeout");
  a_b2_wake_cut: assert property (
    state == FS_MONITOR && variant == VAR_B2 && wake1Fell && !recovered |=> state == FS_OFF)
    else $error("Variant B2 did not cut on wake input low");
  a_b3_needs_both: assert property (
    state == FS_MONITOR && variant == VAR_B3 && !(busIdleExpired && wake1Fell)
    |=> state != FS_OFF)
    else $error("Variant B3 cut without both conditions");
  a_wake_restores: assert property (
    wakeEvt |=> supplyEnable && state == FS_NORMAL ##1 !resetOut_n)
    else $error("Wake did not restore supply and reset");
  a_release_gated: assert property (
    $rose(safe_n) |-> $past(releaseCmd) && $past(causeFlags) == '0)
    else $error("Safe output released without command and clear flags");
  a_release_works: assert property (
    releaseCmd && causeFlags == '0 && causeSet == '0 |=> safe_n)
    else $error("Release command ignored");
  a_wd_first_pulse: assert property (
    wdPulseEvt && !wdSecondSel |=> !safe_n && !resetOut_n)
    else $error("Watchdog pulse did not assert safe output");
  a_supply_low_both: assert property (
    supplyLow && state != FS_OFF |=> !safe_n && !resetOut_n)
    else $error("Supply low did not assert safe and reset together");
  a_clamp_safe: assert property (
    clampFault |=> !safe_n)
    else $error("Reset clamp did not assert safe output");
  a_idle_restart: assert property (
    canAct |=> idleTimer == 32'h0000_0000 && !busIdleExpired)
    else $error("Bus activity did not restart idle timer");
endmodule // fail_safe_supply_controller

/* host_mcu_model.sv */
`timescale 1ns/1ps
module host_mcu_model #(
  parameter int GAP = 16
) (
  input  wire logic        clk,
  input  wire logic        refreshOn,
  input  wire logic        relReq,
  input  wire logic        relClear,
  input  wire logic        relSel,
  output logic             wdRefreshOk,
  output logic             spiWordValid,
  output logic [15:0]      spiWord,
  output logic             flagsClear,
  output logic [3:0]       flagsClearMask
);
  int   gap;
  int   phase;
  logic req;

  initial begin
    gap = 0;
    phase = 0;
    wdRefreshOk = 1'b0;
    spiWordValid = 1'b0;
    spiWord = 16'h0000;
    flagsClear = 1'b0;
    flagsClearMask = 4'h0;
  end

  // Drives a fixed delay after the edge; every strobe lasts one cycle
  always @(posedge clk) begin
    req = relReq;
    #5;
    gap = refreshOn ? (gap + 1) % GAP : 0;
    wdRefreshOk = refreshOn && gap == 0;
    spiWordValid = 1'b0;
    flagsClear = 1'b0;
    // Idle word and mask keep changing so stale values never look valid
    spiWord = ~spiWord;
    flagsClearMask = ~flagsClearMask;
    if (req && phase == 0) begin
      phase = relClear ? 1 : 2;
    end
    if (phase == 1) begin
      flagsClear = 1'b1;
      flagsClearMask = 4'hf;
      phase = 2;
    end else if (phase == 2) begin
      spiWordValid = 1'b1;
      spiWord = relSel ? 16'hdd80 : 16'hdd00;
      phase = 0;
    end
  end
endmodule // host_mcu_model

/* fail_safe_supply_controller_tb_top.sv */
`timescale 1ns/1ps
module fail_safe_supply_controller_tb_top;
  import fail_safe_pkg::*;
  localparam int WD = 64;
  localparam int PULSE = 4;
  localparam int CLAMP = 16;
  localparam int IDLE = 32;
  localparam int RST = 0;
  localparam int SAFE = 1;
  localparam int SUP = 2;
  localparam int INS = 3;

  logic clk, reset_n, clkEn, initDone, cfgWrite, wdRefreshOk, wdSecondSel;
  logic supplyLowPin, resetSenseLowPin, canActivityPin, linActivityPin;
  logic wake1Pin, wake1WakeEn, spiWordValid, flagsClear;
  logic safe_n, supplyEnable, resetOut_n, inSafeState, busIdleExpired;
  logic refreshOn, relReq, relClear, relSel;
  logic [1:0]  strapClass;
  logic [2:0]  cfgCode;
  logic [15:0] spiWord;
  logic [3:0]  flagsClearMask;
  logic [3:0]  causeFlags;
  variant_t    variantSel;
  int          err_total;
  int          comparisons;

  fail_safe_supply_controller #(
    .WD_PERIOD_CYC (WD),
    .RST_PULSE_CYC (PULSE),
    .CLAMP_CYC     (CLAMP),
    .BUS_IDLE_CYC  (IDLE)
  ) u_fail_safe_supply_controller (
    .clk              (clk),
    .reset_n          (reset_n),
    .clkEn            (clkEn),
    .strapClass       (strapClass),
    .initDone         (initDone),
    .cfgWrite         (cfgWrite),
    .cfgCode          (cfgCode),
    .wdRefreshOk      (wdRefreshOk),
    .wdSecondSel      (wdSecondSel),
    .supplyLowPin     (supplyLowPin),
    .resetSenseLowPin (resetSenseLowPin),
    .canActivityPin   (canActivityPin),
    .linActivityPin   (linActivityPin),
    .wake1Pin         (wake1Pin),
    .wake1WakeEn      (wake1WakeEn),
    .spiWordValid     (spiWordValid),
    .spiWord          (spiWord),
    .flagsClear       (flagsClear),
    .flagsClearMask   (flagsClearMask),
    .safe_n           (safe_n),
    .supplyEnable     (supplyEnable),
    .resetOut_n       (resetOut_n),
    .variantSel       (variantSel),
    .causeFlags       (causeFlags),
    .inSafeState      (inSafeState),
    .busIdleExpired   (busIdleExpired)
  );

  host_mcu_model u_host_mcu_model (.clk(clk), .refreshOn(refreshOn), .relReq(relReq),
    .relClear(relClear), .relSel(relSel), .wdRefreshOk(wdRefreshOk),
    .spiWordValid(spiWordValid), .spiWord(spiWord), .flagsClear(flagsClear),
    .flagsClearMask(flagsClearMask));

  always #25 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic chkBit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic chkVar(input variant_t got, input variant_t exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      RST: return resetOut_n;
      SAFE: return safe_n;
      SUP: return supplyEnable;
      default: return inSafeState;
    endcase
  endfunction

  task automatic waitOut(input int s, input logic v, input int lim);
    for (int n = 0; n < lim && pick(s) !== v; n++) cyc(1);
  endtask

  task automatic cfgSet(input logic [2:0] code);
    cfgCode = code;
    cfgWrite = 1'b1;
    cyc(1);
    cfgWrite = 1'b0;
    cyc(1);
  endtask

  task automatic rel(input logic c, input logic s);
    relClear = c;
    relSel = s;
    relReq = 1'b1;
    cyc(1);
    relReq = 1'b0;
    cyc(4);
  endtask

  task automatic canPulse();
    canActivityPin = 1'b1;
    cyc(3);
    canActivityPin = 1'b0;
  endtask

  task automatic variantScn();
    logic [2:0] code;
    initDone = 1'b1;
    cyc(1);
    initDone = 1'b0;
    chkVar(variantSel, VAR_B2, "strap not sampled");
    cfgSet(3'h3);
    chkVar(variantSel, VAR_B2, "invalid code taken");
    for (int c = 7; c >= 4; c--) begin
      code = 3'(c);
      cfgSet(code);
      chkVar(variantSel, variant_t'(2'(7 - c)), "code not applied");
    end
    strapClass = 2'h1;
    cyc(6);
    initDone = 1'b1;
    cyc(1);
    initDone = 1'b0;
    chkVar(variantSel, VAR_B3, "strap beat software");
  endtask

  task automatic watchdogScn();
    int k;
    cfgSet(3'h7);
    refreshOn = 1'b0;
    waitOut(RST, 1'b0, WD + 20);
    chkBit(safe_n, 1'b0, "safe not at first pulse");
    for (k = 0; k < 10 && resetOut_n === 1'b0; k++) cyc(1);
    chkBit(k == PULSE, 1'b1, "pulse length");
    for (k = 0; k < WD + 8 && resetOut_n === 1'b1; k++) cyc(1);
    chkBit(k >= WD - PULSE - 2 && k <= WD, 1'b1, "pulse period");
    cyc(5 * WD);
    chkBit(inSafeState, 1'b0, "safe state too early");
    waitOut(INS, 1'b1, 2 * WD);
    chkBit(inSafeState, 1'b1, "no safe state after eight failures");
    cyc(WD);
    chkBit(supplyEnable, 1'b1, "variant A cut supply");
    refreshOn = 1'b1;
    waitOut(INS, 1'b0, 40);
    chkBit(inSafeState, 1'b0, "no recovery");
    chkBit(safe_n, 1'b0, "safe released on recovery");
    rel(1'b0, 1'b0);
    chkBit(safe_n, 1'b0, "release with flags set");
    rel(1'b1, 1'b1);
    chkBit(safe_n, 1'b1, "second release word ignored");
    chkBit(causeFlags === 4'h0, 1'b1, "flags not cleared");
  endtask

  task automatic busIdleScn();
    cfgSet(3'h6);
    wake1WakeEn = 1'b0;
    canPulse();
    cyc(6);
    chkBit(busIdleExpired, 1'b0, "idle not restarted");
    supplyLowPin = 1'b1;
    waitOut(SAFE, 1'b0, 10);
    chkBit(resetOut_n, 1'b0, "safe and reset not together");
    cyc(IDLE / 2);
    canPulse();
    cyc(IDLE - 8);
    chkBit(supplyEnable, 1'b1, "cut before full idle");
    waitOut(SUP, 1'b0, IDLE + 20);
    chkBit(supplyEnable, 1'b0, "no cut after idle");
    chkBit(busIdleExpired, 1'b1, "idle flag");
    chkBit(causeFlags[3], 1'b1, "cut flag");
    supplyLowPin = 1'b0;
    cyc(8);
    chkBit(supplyEnable, 1'b0, "woke without event");
    canPulse();
    waitOut(SUP, 1'b1, 10);
    chkBit(supplyEnable, 1'b1, "no wake on bus");
    waitOut(RST, 1'b0, 3);
    chkBit(resetOut_n, 1'b0, "no reset on wake");
    chkBit(safe_n, 1'b0, "safe released on wake");
    rel(1'b1, 1'b0);
    chkBit(safe_n, 1'b1, "first release word ignored");
    wake1WakeEn = 1'b1;
  endtask

  task automatic wakePinScn();
    cfgSet(3'h5);
    resetSenseLowPin = 1'b1;
    cyc(CLAMP);
    chkBit(inSafeState, 1'b0, "clamp too early");
    waitOut(INS, 1'b1, 20);
    chkBit(safe_n, 1'b0, "clamp not detected");
    wake1Pin = 1'b0;
    waitOut(SUP, 1'b0, 10);
    chkBit(supplyEnable, 1'b0, "no cut on wake input fall");
    resetSenseLowPin = 1'b0;
    wake1Pin = 1'b1;
    waitOut(SUP, 1'b1, 10);
    chkBit(supplyEnable, 1'b1, "no wake on wake input");
    rel(1'b1, 1'b1);
  endtask

  task automatic bothScn();
    cfgSet(3'h4);
    cyc(IDLE + 10);
    chkBit(busIdleExpired, 1'b1, "idle not expired");
    supplyLowPin = 1'b1;
    cyc(20);
    chkBit(supplyEnable, 1'b1, "cut on idle alone");
    wake1Pin = 1'b0;
    waitOut(SUP, 1'b0, 10);
    chkBit(supplyEnable, 1'b0, "no cut on both");
    supplyLowPin = 1'b0;
    linActivityPin = 1'b1;
    waitOut(SUP, 1'b1, 10);
    chkBit(supplyEnable, 1'b1, "no wake on LIN");
    linActivityPin = 1'b0;
    wake1Pin = 1'b1;
    cyc(PULSE + 4);
    rel(1'b1, 1'b0);
  endtask

  task automatic secondPulseScn();
    wdSecondSel = 1'b1;
    refreshOn = 1'b0;
    waitOut(RST, 1'b0, WD + 20);
    chkBit(safe_n, 1'b1, "safe at first pulse");
    waitOut(RST, 1'b1, PULSE + 2);
    waitOut(RST, 1'b0, WD + 4);
    chkBit(safe_n, 1'b0, "safe not at second pulse");
    clkEn = 1'b0;
    cyc(PULSE + 2);
    chkBit(resetOut_n, 1'b0, "clock enable did not freeze");
    clkEn = 1'b1;
    cyc(PULSE + 1);
    chkBit(resetOut_n, 1'b1, "pulse did not resume");
  endtask

  task automatic conclude();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    err_total++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    strapClass = 2'h2;
    {initDone, cfgWrite, cfgCode, wdSecondSel} = 6'h00;
    {supplyLowPin, resetSenseLowPin, canActivityPin, linActivityPin} = 4'h0;
    wake1Pin = 1'b1;
    wake1WakeEn = 1'b1;
    refreshOn = 1'b1;
    {relReq, relClear, relSel} = 3'h0;
    err_total = 0;
    comparisons = 0;
    cyc(16);
    reset_n = 1'b1;
    cyc(6);
    variantScn();
    watchdogScn();
    busIdleScn();
    wakePinScn();
    bothScn();
    secondPulseScn();
    conclude();
  end
endmodule // fail_safe_supply_controller_tb_top
